// ===== rtl/gige_phy_status_defs.vh
// Offsets, field positions, reset values and codes of the gigabit status and MMD registers
`ifndef GIGE_PHY_STATUS_DEFS_VH
`define GIGE_PHY_STATUS_DEFS_VH

// Register indices as printed; byte address is four times the index
`define IDX_GIG_STATUS 4'ha
`define IDX_MMD_CTRL 4'hd
`define IDX_MMD_WINDOW 4'he
`define IDX_EXT_STATUS 4'hf
`define ADDR_GIG_STATUS 12'h028
`define ADDR_MMD_CTRL 12'h034
`define ADDR_MMD_WINDOW 12'h038
`define ADDR_EXT_STATUS 12'h03c

// Gigabit status field positions
`define GS_MS_RES_BIT 14
`define GS_LOC_RX_BIT 13
`define GS_REM_RX_BIT 12
`define GS_LP_FD_BIT 11
`define GS_LP_HD_BIT 10
`define GS_IDLE_ERR_MAX 8'hff
`define GS_IDLE_ERR_RST 8'h00

// MMD control field positions and codes
`define MC_OP_HI 15
`define MC_OP_LO 14
`define MC_DEV_HI 4
`define MC_DEV_LO 0
`define MC_RST 16'h0000
`define MMD_OP_ADDR 2'b00
`define MMD_OP_DATA 2'b01
`define MMD_OP_INC_RW 2'b10
`define MMD_OP_INC_WR 2'b11
`define WINDOW_RST 16'h0000

// Extended status constant value
`define EXT_STATUS_VAL 16'h3000

// Storage behind the MMD window
`define MMD_DEV_BITS 5
`define MMD_REG_BITS 3
`define MMD_WORDS 256

`endif

// ===== rtl/idle_error_counter.v
// Saturating idle error counter that clears on a status read
`timescale 1ns/1ps
`include "gige_phy_status_defs.vh"

module idle_error_counter
(
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Events
    input wire idle_err_event,
    input wire clear_req,
    // Count
    output reg [7:0] count_q
);

    reg [7:0] count_d;

    // ==========================================================
    // Next count
    // An event during the clearing read counts as the new first error
    always @*
    begin
        count_d = count_q;
        if (clear_req)
        begin
            count_d = idle_err_event ? 8'h01 : `GS_IDLE_ERR_RST;
        end
        else if (idle_err_event && (count_q != `GS_IDLE_ERR_MAX))
        begin
            count_d = count_q + 8'h01;
        end
    end

    // Counter flop
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_q <= `GS_IDLE_ERR_RST;
        end
        else
        begin
            count_q <= count_d;
        end
    end

endmodule

// ===== rtl/gige_phy_status_mmd_regs.v
// Gigabit status, MMD indirect access and extended status registers on APB
`timescale 1ns/1ps
`include "gige_phy_status_defs.vh"

// How it works
// - Bit 14 shows master/slave resolution, read-only, resets to zero.
// - Bit 13 mirrors local receiver OK, read-only, resets zero.
// - Bit 12 mirrors remote receiver OK, read-only, resets zero.
// - Bits 11 and 10 show partner gigabit full and half duplex.
// - Bits 7:0 count idle errors while receiving idles in SEND_N mode.
// - Counter steps once per symbol period with receive error status ERROR.
// - Control bits 4:0 hold MMD device address, reset zero.
// - Control bits 15:14: 00 address access, others data access.
// - Mode 01 keeps stored register address after data access.
// - Mode 10 increments address after every data read and write.
// - Mode 11 increments address after data writes only.
// - Data modes window reads and writes MMD data at stored address.
// - Extended status bits 15 and 14 read zero.
// - Extended status bits 13 and 12 read one.
module gige_phy_status_mmd_regs
(
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Line status from the PMA
    input wire ms_resolved_master,
    input wire loc_rcvr_ok,
    input wire rem_rcvr_ok,
    input wire lp_1000t_fd,
    input wire lp_1000t_hd,
    // Idle error detection
    input wire symbol_tick,
    input wire rx_idle,
    input wire tx_mode_send_n,
    input wire rx_error,
    // Current MMD selection for observers
    output reg [4:0] mmd_dev_sel,
    output reg [15:0] mmd_reg_addr
);

    // ==========================================================
    // Declarations
    reg [15:0] ctrl_q;
    reg [15:0] ctrl_d;
    reg [15:0] addr_q [0:31];
    reg [15:0] data_q [0:`MMD_WORDS-1];
    reg [15:0] gstat_q;
    reg [31:0] rdata_d;
    reg slverr_d;
    wire [7:0] idle_cnt;
    wire setup;
    wire wr_en;
    wire rd_gstat;
    wire [1:0] op;
    wire [4:0] dev;
    wire [15:0] cur_addr;
    wire [7:0] data_idx;
    wire idle_evt;
    wire inc_now;
    integer i;

    // Storage index from device and register address; MMD space is sparse here
    function [7:0] mmd_index;
        input [4:0] d;
        input [15:0] a;
        begin
            mmd_index = {d, a[`MMD_REG_BITS-1:0]};
        end
    endfunction

    // Address decode helper used by write and read paths
    function hit;
        input [11:0] a;
        input [11:0] ref_a;
        begin
            hit = (a == ref_a);
        end
    endfunction

    // ==========================================================
    // APB phases
    // Zero wait state: answer in the first access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign rd_gstat = setup && !pwrite && hit(paddr, `ADDR_GIG_STATUS);

    assign op = ctrl_q[`MC_OP_HI:`MC_OP_LO];
    assign dev = ctrl_q[`MC_DEV_HI:`MC_DEV_LO];
    assign cur_addr = addr_q[dev];
    assign data_idx = mmd_index(dev, cur_addr);

    // ==========================================================
    // Idle error counter
    // Qualify by symbol period so long symbols count only once
    assign idle_evt = symbol_tick && rx_idle && tx_mode_send_n && rx_error;

    idle_error_counter u_idle_cnt
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .idle_err_event(idle_evt),
        .clear_req(rd_gstat),
        .count_q(idle_cnt)
    );

    // ==========================================================
    // Status snapshot, registered so reads see a stable word
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gstat_q <= 16'h0000;
        end
        else
        begin
            gstat_q <= {1'b0, ms_resolved_master, loc_rcvr_ok, rem_rcvr_ok,
                        lp_1000t_fd, lp_1000t_hd, 2'b00, idle_cnt};
        end
    end

    // ==========================================================
    // Control register with byte strobes
    always @*
    begin
        ctrl_d = ctrl_q;
        if (wr_en && hit(paddr, `ADDR_MMD_CTRL))
        begin
            if (pstrb[0])
            begin
                ctrl_d[7:0] = pwdata[7:0];
            end
            if (pstrb[1])
            begin
                ctrl_d[15:8] = pwdata[15:8];
            end
        end
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= `MC_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // Post-increment decision on a window access in data mode
    assign inc_now = psel && penable && hit(paddr, `ADDR_MMD_WINDOW) &&
                     ((op == `MMD_OP_INC_RW) ||
                      ((op == `MMD_OP_INC_WR) && pwrite));

    // Per-device register address and data storage
    // The address array is small; data array is a plain register bank
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < 32; i = i + 1)
            begin
                addr_q[i] <= `WINDOW_RST;
            end
            for (i = 0; i < `MMD_WORDS; i = i + 1)
            begin
                data_q[i] <= `WINDOW_RST;
            end
        end
        else if (psel && penable && hit(paddr, `ADDR_MMD_WINDOW))
        begin
            if (op == `MMD_OP_ADDR)
            begin
                if (pwrite)
                begin
                    addr_q[dev] <= pwdata[15:0];
                end
            end
            else
            begin
                if (pwrite)
                begin
                    data_q[data_idx] <= pwdata[15:0];
                end
                if (inc_now)
                begin
                    addr_q[dev] <= cur_addr + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses answer with an error and zero data
    always @*
    begin
        rdata_d = 32'h0000_0000;
        slverr_d = 1'b0;
        if (hit(paddr, `ADDR_GIG_STATUS))
        begin
            rdata_d = {16'h0000, gstat_q[15:8], idle_cnt};
        end
        else if (hit(paddr, `ADDR_MMD_CTRL))
        begin
            rdata_d = {16'h0000, ctrl_q};
        end
        else if (hit(paddr, `ADDR_MMD_WINDOW))
        begin
            if (op == `MMD_OP_ADDR)
            begin
                rdata_d = {16'h0000, cur_addr};
            end
            else
            begin
                rdata_d = {16'h0000, data_q[data_idx]};
            end
        end
        else if (hit(paddr, `ADDR_EXT_STATUS))
        begin
            rdata_d = {16'h0000, `EXT_STATUS_VAL};
        end
        else
        begin
            slverr_d = 1'b1;
        end
    end

    // ==========================================================
    // Bus outputs: pready and data set during setup, valid in access
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & slverr_d;
            if (setup && !pwrite)
            begin
                prdata <= rdata_d;
            end
        end
    end

    // Observers of current selection
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mmd_dev_sel <= 5'h00;
            mmd_reg_addr <= 16'h0000;
        end
        else
        begin
            mmd_dev_sel <= dev;
            mmd_reg_addr <= cur_addr;
        end
    end

endmodule

// ===== sim/gige_phy_status_sva.sv
// Checker for the gigabit status, MMD control and extended status ports
`timescale 1ns/1ps
`include "gige_phy_status_defs.vh"
module gige_phy_status_sva
(
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Line status and selection
    input wire ms_resolved_master,
    input wire loc_rcvr_ok,
    input wire rem_rcvr_ok,
    input wire lp_1000t_fd,
    input wire lp_1000t_hd,
    input wire [4:0] mmd_dev_sel
);
    // ========================================
    // Decoded cycles, kept as plain wires for the sampled-value calls
    wire setup = psel && !penable;
    wire st_rd = setup && !pwrite && paddr == `ADDR_GIG_STATUS;
    wire ext_rd = setup && !pwrite && paddr == `ADDR_EXT_STATUS;
    wire ctl_wr = psel && penable && pready && pwrite && paddr == `ADDR_MMD_CTRL;
    wire bad = paddr != `ADDR_GIG_STATUS && paddr != `ADDR_MMD_CTRL &&
        paddr != `ADDR_MMD_WINDOW && paddr != `ADDR_EXT_STATUS;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_ms_bit: assert property (st_rd |=> prdata[14] == $past(ms_resolved_master, 2))
        else $error("master bit wrong");
    a_line_bits: assert property (st_rd |=> prdata[13:10] == {$past(loc_rcvr_ok, 2),
        $past(rem_rcvr_ok, 2), $past(lp_1000t_fd, 2), $past(lp_1000t_hd, 2)})
        else $error("line status bits wrong");
    a_rsvd_zero: assert property (st_rd |=> prdata[31:15] == 0 && prdata[9:8] == 0)
        else $error("reserved status bits set");
    a_ext_const: assert property (ext_rd |=> prdata == 32'h0000_3000)
        else $error("extended status wrong");
    a_dev_field: assert property (ctl_wr && pstrb[0] |=> ##1 mmd_dev_sel == $past(pwdata[4:0], 2))
        else $error("device select not taken");
    a_dev_quiet: assert property (!$stable(mmd_dev_sel) |-> $past(ctl_wr, 2))
        else $error("device select moved alone");
    a_ready_next: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_err_flag: assert property (setup |=> pslverr == $past(bad))
        else $error("error flag wrong");
endmodule
bind gige_phy_status_mmd_regs gige_phy_status_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ms_resolved_master(ms_resolved_master), .loc_rcvr_ok(loc_rcvr_ok),
    .rem_rcvr_ok(rem_rcvr_ok), .lp_1000t_fd(lp_1000t_fd), .lp_1000t_hd(lp_1000t_hd),
    .mmd_dev_sel(mmd_dev_sel));

// ===== sim/pma_model.sv
// Line-side model that sends counted idle errors and near misses
`timescale 1ns/1ps
module pma_model
(
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Burst request
    input wire load,
    input wire [8:0] n_err,
    // Idle error events
    output reg symbol_tick,
    output reg rx_idle,
    output reg tx_mode_send_n,
    output reg rx_error
);
    reg [8:0] left_q;
    reg [1:0] ph_q;
    wire busy = left_q != 9'h000;
    // ========================================
    // Burst of full matches; between bursts one condition is always missing
    always @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            left_q <= 0;
            ph_q <= 0;
            {symbol_tick, rx_idle, tx_mode_send_n, rx_error} <= 4'h0;
        end
        else
        begin
            left_q <= load ? n_err : left_q - {8'h00, busy};
            ph_q <= ph_q + 2'b01;
            // Outside a burst each qualifier in turn is the one left low
            rx_idle <= busy || ph_q != 2'd0;
            tx_mode_send_n <= busy || ph_q != 2'd1;
            symbol_tick <= busy || ph_q != 2'd2;
            rx_error <= busy || ph_q != 2'd3;
        end
endmodule

// ===== sim/gige_phy_status_mmd_regs_tb_top.sv
// Self-checking bench for the gigabit status and MMD access registers
`timescale 1ns/1ps
`include "gige_phy_status_defs.vh"
module gige_phy_status_mmd_regs_tb_top;
    localparam [11:0] st_a = `ADDR_GIG_STATUS;
    localparam [11:0] ctrl_a = `ADDR_MMD_CTRL;
    localparam [11:0] win_a = `ADDR_MMD_WINDOW;
    localparam [11:0] ext_a = `ADDR_EXT_STATUS;
    reg core_clk = 0;
    reg rst_b = 0;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg [4:0] st = 0;
    reg load = 0;
    reg [8:0] n_err = 0;
    reg [15:0] a, b, c, d;
    reg [32:0] expq[$];
    reg [20:0] aq[$];
    reg [3:0] strb = 4'hf;
    integer fail_count = 0;
    integer checks = 0;
    wire [31:0] prdata;
    wire pready, pslverr, tick, idle, send_n, rx_err;
    wire [4:0] dev;
    wire [15:0] raddr;
    // ========================================
    // Design and line model; byte lanes driven by the bench
    gige_phy_status_mmd_regs dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ms_resolved_master(st[4]),
        .loc_rcvr_ok(st[3]), .rem_rcvr_ok(st[2]), .lp_1000t_fd(st[1]), .lp_1000t_hd(st[0]),
        .symbol_tick(tick), .rx_idle(idle), .tx_mode_send_n(send_n), .rx_error(rx_err),
        .mmd_dev_sel(dev), .mmd_reg_addr(raddr));
    pma_model u_pma (.core_clk(core_clk), .rst_b(rst_b), .load(load), .n_err(n_err),
        .symbol_tick(tick), .rx_idle(idle), .tx_mode_send_n(send_n), .rx_error(rx_err));
    // 25 MHz clock
    initial
        forever #20 core_clk = ~core_clk;
    task chk(input [32:0] seen, input [32:0] exp);
    begin
        checks = checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // One APB transfer; request held until ready is seen, idle cycle after
    task xfer(input [11:0] ad, input w, input [31:0] wd);
        integer n;
    begin
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (n == 16)
        begin
            fail_count = fail_count + 1;
            stop_test;
        end
        else
        begin
            psel <= 0;
            penable <= 0;
        end
    end
    endtask
    task wr(input [11:0] ad, input [31:0] wd);
        xfer(ad, 1'b1, wd);
    endtask
    // Expected error flag comes from the address map alone
    task rd(input [11:0] ad, input [31:0] e);
    begin
        expq.push_back({ad != st_a && ad != ctrl_a && ad != win_a && ad != ext_a, e});
        xfer(ad, 1'b0, 32'h0000_0000);
    end
    endtask
    // Window read that also notes the device and stored address expected
    task rdw(input [31:0] e, input [4:0] dv, input [15:0] ea);
    begin
        aq.push_back({dv, ea});
        rd(win_a, e);
    end
    endtask
    task burst(input [8:0] k);
    begin
        @(posedge core_clk);
        load <= 1;
        n_err <= k;
        @(posedge core_clk);
        load <= 0;
        repeat (k + 4) @(posedge core_clk);
    end
    endtask
    function [31:0] ctl(input [1:0] op);
        ctl = {16'h0000, op, 9'h000, 5'd3};
    endfunction
    // Read results checked in order of issue, at the ready edge
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, expq.pop_front());
    // Selection outputs lag one cycle, so they are settled by a window read
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite && paddr == win_a)
            chk({12'h000, dev, raddr}, {12'h000, aq.pop_front()});
    initial
    begin
        a = 16'($urandom(32'hda06d971));
        b = 16'($urandom);
        c = 16'($urandom);
        d = 16'($urandom);
        repeat (6) @(posedge core_clk);
        rst_b <= 1;
        rd(st_a, 0);
        rd(ctrl_a, 0);
        rdw(0, 5'd0, 16'h0000);
        wr(ext_a, 32'hffff_ffff);
        rd(ext_a, 32'h0000_3000);
        rd(12'h040, 0);
        repeat (4)
        begin
            @(posedge core_clk);
            st <= 5'($urandom);
            wr(st_a, 32'hffff_ffff);
            rd(st_a, {17'h0, st, 10'h000});
        end
        burst(9'd5);
        rd(st_a, {17'h0, st, 10'h005});
        rd(st_a, {17'h0, st, 10'h000});
        burst(9'd300);
        rd(st_a, {17'h0, st, 10'h0ff});
        wr(ctrl_a, {16'h0000, 2'b00, 9'h1a5, 5'd3});
        rd(ctrl_a, {16'h0000, 2'b00, 9'h1a5, 5'd3});
        wr(win_a, 5);
        rdw(5, 5'd3, 16'h0005);
        wr(ctrl_a, ctl(2'b01));
        wr(win_a, a);
        rdw(a, 5'd3, 16'h0005);
        rdw(a, 5'd3, 16'h0005);
        wr(ctrl_a, ctl(2'b10));
        wr(win_a, b);
        wr(win_a, c);
        wr(ctrl_a, ctl(2'b00));
        rdw(7, 5'd3, 16'h0007);
        wr(win_a, 5);
        wr(ctrl_a, ctl(2'b10));
        rdw(b, 5'd3, 16'h0005);
        rdw(c, 5'd3, 16'h0006);
        wr(ctrl_a, ctl(2'b00));
        wr(win_a, 5);
        wr(ctrl_a, ctl(2'b11));
        rdw(b, 5'd3, 16'h0005);
        rdw(b, 5'd3, 16'h0005);
        wr(win_a, d);
        rdw(c, 5'd3, 16'h0006);
        wr(ctrl_a, ctl(2'b00));
        rdw(6, 5'd3, 16'h0006);
        // Upper lane only: mode and reserved bits 13:8 change, bits 7:5 and device field must stay
        strb <= 4'h2;
        wr(ctrl_a, 32'h0000_bfe9);
        strb <= 4'hf;
        rd(ctrl_a, 32'h0000_bf03);
        rdw(c, 5'd3, 16'h0006);
        // Let the last read's checks run before the verdict
        repeat (2) @(posedge core_clk);
        stop_test;
    end
endmodule
